/* File: bdde_pkg.sv */
// Shared constants for the two-channel descriptor DMA engine and its bus side.
// Assumes one clock, mclk, shared by both ends of the link.
package bdde_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int CH_N = 2;
   localparam int CFG_AW = 4;
   localparam int MODE_W = 12;
   localparam int WAIT_LO = 8;
   localparam int WAIT_W = 4;
   localparam logic BUS_PCI = 1'b0;
   localparam logic BUS_LOC = 1'b1;
   // ****************************************
   // Channel registers, index in cfgAddr[2:0], channel in cfgAddr[3]
   // ****************************************
   localparam logic [2:0] REG_MODE = 3'h0;
   localparam logic [2:0] REG_PCIA = 3'h1;
   localparam logic [2:0] REG_LOCA = 3'h2;
   localparam logic [2:0] REG_CNT = 3'h3;
   localparam logic [2:0] REG_DESC = 3'h4;
   localparam logic [2:0] REG_CSR = 3'h5;
   localparam logic [2:0] REG_ACT = 3'h6;
   // Mode bits
   localparam int M_SG = 0;
   localparam int M_RING = 1;
   localparam int M_DLOC = 2;
   localparam int M_WB = 3;
   localparam int M_DEMAND = 4;
   localparam int M_SWAP = 5;
   localparam int M_TOLOC = 6;
   localparam int M_ENDLESS = 7;
   // Control and status bits
   localparam int C_GO = 0;
   localparam int C_DONE = 1;
   localparam int C_EOT = 2;
   localparam int C_PERR = 3;
   localparam int C_BUSY = 4;
   // ****************************************
   // Descriptor: four words, byte offsets word*4
   // ****************************************
   localparam logic [1:0] D_PCIA = 2'h0;
   localparam logic [1:0] D_LOCA = 2'h1;
   localparam logic [1:0] D_CNT = 2'h2;
   localparam logic [1:0] D_CTL = 2'h3;
   localparam int DC_VALID = 0;
   localparam int DC_LAST = 1;
   localparam int DC_DIR = 2;
   localparam int DC_SERVICED = 3;
   // ****************************************
   // Bus side command map, Avalon word addresses
   // ****************************************
   localparam int AV_AW = 8;
   localparam logic [7:0] AV_MEM_BASE = 8'h40;
   localparam logic [7:0] AV_CTRL = 8'h80;
   localparam logic [7:0] AV_STAT = 8'h81;
   localparam int K_EOT = 0;
   localparam int K_DMA_REQUEST_N = 2;
   localparam int K_DIRECT = 4;
   localparam int K_RETRY = 6;
   localparam int K_PFLIP = 8;
   localparam logic [1:0] AV_WAIT_LAST = 2'h2;
   typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_RD, ST_WR, ST_WB, ST_NEXT} bdde_state_t;
endpackage

/* File: bdde_link_if.sv */
// Link between the DMA engine and the bridge buses, peripherals and command side.
// Assumes both ends run on the same clock; no clocking block.
interface bdde_link_if;
   import bdde_pkg::*;
   // Register port
   logic cfgWr;
   logic cfgRd;
   logic [CFG_AW-1:0] cfgAddr;
   logic [31:0] cfgWdata;
   logic [31:0] cfgRdata;
   // Bus masters, index 0 PCI and 1 local
   logic [1:0] busReq;
   logic [1:0] busWe;
   logic [1:0][31:0] busAddr;
   logic [1:0][31:0] busWdata;
   logic [1:0][3:0] busBe;
   logic [1:0][31:0] busRdata;
   logic [1:0] busPar;
   logic [1:0] busAck;
   logic [1:0] busRetry;
   logic [1:0] directBusy;
   // Peripheral controls, one per channel
   logic [CH_N-1:0] eotN;
   logic [CH_N-1:0] dreqN;
   logic [CH_N-1:0] dackN;
   modport dev(input cfgWr, cfgRd, cfgAddr, cfgWdata, busRdata, busPar, busAck, busRetry,
      directBusy, eotN, dreqN, output cfgRdata, busReq, busWe, busAddr, busWdata, busBe, dackN);
   modport host(output cfgWr, cfgRd, cfgAddr, cfgWdata, busRdata, busPar, busAck, busRetry,
      directBusy, eotN, dreqN, input cfgRdata, busReq, busWe, busAddr, busWdata, busBe, dackN);
endinterface

/* File: bdde_engine.sv */
// Two-channel descriptor DMA engine, mastering the PCI and local buses.
// Assumes the bus side answers each request with one ack or retry pulse.
// How it works
// - Block mode: registers plus launch run whole transfer
// - Completion sets a pollable done status bit
// - Chain mode walks descriptors from first pointer
// - Descriptors fetched from PCI or local memory
// - Linear and ring descriptor lists both supported
// - Ring services valid descriptors, clears valid after
// - Master fills invalid descriptors, then sets valid
// - Write-back count and status before valid clear
// - Peripheral ends transfer early by end-of-transfer low
// - End-of-transfer aborts at once, writes actual count
// - Endless bursts run until end-of-transfer
// - Per-channel request/acknowledge pair pauses and resumes
// - Peripheral pauses when full or empty
// - Each channel has its own data buffer
// - Engine masters both PCI and local bus
// - Retry on a bus switches to other channel if it is active
// - DMA runs alongside direct bridge traffic
// - Direct transfers win the bus over DMA
// - Unaligned addresses and lengths handled
// - Optional byte swap on local bus data
// - Programmable wait states between local accesses
// - Parity checked on data from both buses
// - Exactly two channels, zero and one
module bdde_engine
   import bdde_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Bridge side
   bdde_link_if.dev lnk,
   // Channel activity
   output logic [CH_N-1:0] chBusy
);
   // ****************************************
   // Per-channel context
   // ****************************************
   logic [31:0] pciA [CH_N];
   logic [31:0] locA [CH_N];
   logic [31:0] cnt [CH_N];
   logic [31:0] descP [CH_N];
   logic [31:0] actual [CH_N];
   logic [31:0] ctlR [CH_N];
   logic [31:0] fifoW [CH_N];
   logic [2:0] fifoN [CH_N];
   logic [1:0] step [CH_N];
   logic [MODE_W-1:0] modeR [CH_N];
   bdde_state_t st [CH_N];
   logic [CH_N-1:0] dirR;
   logic [CH_N-1:0] done;
   logic [CH_N-1:0] eotSeen;
   logic [CH_N-1:0] perr;
   logic [CH_N-1:0] dackR;
   logic cur;
   logic [1:0] busReqR;
   logic reqBus;
   logic reqWe;
   logic [31:0] reqAddr;
   logic [31:0] reqData;
   logic [3:0] reqBe;
   logic [WAIT_W-1:0] waitCnt;
   logic [31:0] cfgRdR;

   function automatic logic [31:0] swapB(input logic [31:0] d);
      return {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction

   function automatic bdde_state_t finishTo(input logic [MODE_W-1:0] m);
      if (!m[M_SG]) begin
         return ST_IDLE;
      end
      return (m[M_WB] || m[M_RING]) ? ST_WB : ST_NEXT;
   endfunction

   // ****************************************
   // Current channel decode
   // ****************************************
   wire reqOn = |busReqR;
   wire toLoc = dirR[cur];
   wire [31:0] srcA = toLoc ? pciA[cur] : locA[cur];
   wire [31:0] dstA = toLoc ? locA[cur] : pciA[cur];
   wire srcBus = toLoc ? BUS_PCI : BUS_LOC;
   wire dstBus = toLoc ? BUS_LOC : BUS_PCI;
   wire descBus = modeR[cur][M_DLOC] ? BUS_LOC : BUS_PCI;
   wire swapOn = modeR[cur][M_SWAP];
   wire endless = modeR[cur][M_ENDLESS];
   wire dataDone = !endless && cnt[cur] == 32'h0000_0000;
   wire [2:0] roomS = 3'(3'd4 - {1'b0, srcA[1:0]});
   wire [2:0] roomD = 3'(3'd4 - {1'b0, dstA[1:0]});
   wire [2:0] room = (roomS < roomD) ? roomS : roomD;
   wire [2:0] nB = (endless || cnt[cur] >= {29'h0, room}) ? room : cnt[cur][2:0];
   wire inData = st[cur] == ST_RD || st[cur] == ST_WR;
   wire paused = modeR[cur][M_DEMAND] && lnk.dreqN[cur] && inData;
   wire runnable = st[cur] != ST_IDLE && !paused;
   wire [4:0] oneHot = 5'(5'd1 << fifoN[cur]);
   wire [3:0] beRaw = 4'(oneHot - 5'd1);
   wire [3:0] beSh = 4'(beRaw << dstA[1:0]);
   wire [31:0] wrSh = fifoW[cur] << {dstA[1:0], 3'b000};
   wire dstSwap = dstBus == BUS_LOC && swapOn;
   wire [31:0] rdRaw = lnk.busRdata[reqBus];
   wire [31:0] rdSw = (reqBus == BUS_LOC && swapOn) ? swapB(rdRaw) : rdRaw;
   wire [31:0] rdAl = rdSw >> {srcA[1:0], 3'b000};
   wire parBad = (^rdRaw) != lnk.busPar[reqBus];
   wire ackIn = reqOn && lnk.busAck[reqBus];
   wire retryIn = reqOn && lnk.busRetry[reqBus];
   wire [1:0] wbOff = (step[cur] == 2'd0) ? D_CNT : D_CTL;
   wire [31:0] ctlDone = ctlR[cur] | (32'h0000_0001 << DC_SERVICED);
   wire cfgCh = lnk.cfgAddr[3];
   wire [2:0] cfgReg = lnk.cfgAddr[2:0];
   wire launch = lnk.cfgWr && cfgReg == REG_CSR && lnk.cfgWdata[C_GO] && st[cfgCh] == ST_IDLE;

   logic needBus;
   logic opBus;
   logic opWe;
   logic [31:0] opAddr;
   logic [31:0] opData;
   logic [3:0] opBe;

   // ****************************************
   // Next bus operation of the current channel
   // ****************************************
   always_comb begin
      needBus = 1'b0;
      opBus = BUS_PCI;
      opWe = 1'b0;
      opAddr = 32'h0000_0000;
      opData = 32'h0000_0000;
      opBe = 4'hF;
      unique case (st[cur])
         ST_FETCH: begin
            needBus = 1'b1;
            opBus = descBus;
            opAddr = descP[cur] + {28'h0, step[cur], 2'b00};
         end
         ST_RD: begin
            needBus = !dataDone;
            opBus = srcBus;
            opAddr = {srcA[31:2], 2'b00};
         end
         ST_WR: begin
            needBus = 1'b1;
            opBus = dstBus;
            opWe = 1'b1;
            opAddr = {dstA[31:2], 2'b00};
            opData = dstSwap ? swapB(wrSh) : wrSh;
            opBe = dstSwap ? {beSh[0], beSh[1], beSh[2], beSh[3]} : beSh;
         end
         ST_WB: begin
            needBus = 1'b1;
            opBus = descBus;
            opWe = 1'b1;
            opAddr = descP[cur] + {28'h0, wbOff, 2'b00};
            opData = (step[cur] == 2'd0) ? actual[cur] : ctlDone;
            if (step[cur] == 2'd2) begin
               opData = ctlDone & ~(32'h0000_0001 << DC_VALID);
            end
         end
         default: begin
            needBus = 1'b0;
         end
      endcase
   end

   // Direct traffic keeps the bus while it is busy; DMA only fills the gaps
   wire startOk = !reqOn && runnable && needBus && !lnk.directBusy[opBus]
      && !(opBus == BUS_LOC && waitCnt != 4'h0);

   assign lnk.busReq = busReqR;
   assign lnk.busWe = {reqWe, reqWe};
   assign lnk.busAddr = {reqAddr, reqAddr};
   assign lnk.busWdata = {reqData, reqData};
   assign lnk.busBe = {reqBe, reqBe};
   assign lnk.dackN = dackR;
   assign lnk.cfgRdata = cfgRdR;

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < CH_N; i++) begin
            pciA[i] <= 32'h0000_0000;
            locA[i] <= 32'h0000_0000;
            cnt[i] <= 32'h0000_0000;
            descP[i] <= 32'h0000_0000;
            actual[i] <= 32'h0000_0000;
            ctlR[i] <= 32'h0000_0000;
            fifoW[i] <= 32'h0000_0000;
            fifoN[i] <= 3'h0;
            step[i] <= 2'h0;
            modeR[i] <= '0;
            st[i] <= ST_IDLE;
         end
         dirR <= '0;
         done <= '0;
         eotSeen <= '0;
         perr <= '0;
         dackR <= '1;
         chBusy <= '0;
         cur <= 1'b0;
         busReqR <= 2'b00;
         reqBus <= BUS_PCI;
         reqWe <= 1'b0;
         reqAddr <= 32'h0000_0000;
         reqData <= 32'h0000_0000;
         reqBe <= 4'h0;
         waitCnt <= '0;
         cfgRdR <= 32'h0000_0000;
      end else begin
         if (waitCnt != 4'h0) begin
            waitCnt <= waitCnt - 4'h1;
         end
         if (!reqOn) begin
            if (startOk) begin
               busReqR <= (opBus == BUS_LOC) ? 2'b10 : 2'b01;
               reqBus <= opBus;
               reqWe <= opWe;
               reqAddr <= opAddr;
               reqData <= opData;
               reqBe <= opBe;
            end else if (runnable && st[cur] == ST_RD && dataDone) begin
               st[cur] <= finishTo(modeR[cur]);
               step[cur] <= modeR[cur][M_WB] ? 2'd0 : 2'd2;
               done[cur] <= !modeR[cur][M_SG];
            end else if (st[cur] == ST_NEXT) begin
               if ((ctlR[cur][DC_LAST] && !modeR[cur][M_RING]) || eotSeen[cur]) begin
                  st[cur] <= ST_IDLE;
                  done[cur] <= 1'b1;
               end else begin
                  descP[cur] <= {ctlR[cur][31:4], 4'h0};
                  step[cur] <= 2'd0;
                  st[cur] <= ST_FETCH;
               end
            end else if (!runnable) begin
               cur <= ~cur;
            end
         end else if (retryIn) begin
            busReqR <= 2'b00;
            if (st[~cur] != ST_IDLE) begin
               cur <= ~cur;
            end
         end else if (ackIn) begin
            busReqR <= 2'b00;
            if (reqBus == BUS_LOC) begin
               waitCnt <= modeR[cur][WAIT_LO +: WAIT_W];
            end
            if (!reqWe && parBad) begin
               perr[cur] <= 1'b1;
            end
            unique case (st[cur])
               ST_FETCH: begin
                  step[cur] <= 2'(step[cur] + 2'd1);
                  unique case (step[cur])
                     D_PCIA: pciA[cur] <= rdRaw;
                     D_LOCA: locA[cur] <= rdRaw;
                     D_CNT: cnt[cur] <= rdRaw;
                     default: begin
                        ctlR[cur] <= rdRaw;
                        if (modeR[cur][M_RING] && !rdRaw[DC_VALID]) begin
                           cur <= ~cur;
                        end else begin
                           dirR[cur] <= rdRaw[DC_DIR];
                           actual[cur] <= 32'h0000_0000;
                           st[cur] <= ST_RD;
                        end
                     end
                  endcase
               end
               ST_RD: begin
                  fifoW[cur] <= rdAl;
                  fifoN[cur] <= nB;
                  st[cur] <= ST_WR;
               end
               ST_WR: begin
                  pciA[cur] <= pciA[cur] + {29'h0, fifoN[cur]};
                  locA[cur] <= locA[cur] + {29'h0, fifoN[cur]};
                  if (!endless) begin
                     cnt[cur] <= cnt[cur] - {29'h0, fifoN[cur]};
                  end
                  actual[cur] <= actual[cur] + {29'h0, fifoN[cur]};
                  st[cur] <= ST_RD;
               end
               ST_WB: begin
                  if (step[cur] == 2'd0) begin
                     step[cur] <= 2'd1;
                  end else if (step[cur] == 2'd1 && modeR[cur][M_RING]) begin
                     step[cur] <= 2'd2;
                  end else begin
                     st[cur] <= ST_NEXT;
                  end
               end
               default: begin
                  st[cur] <= st[cur];
               end
            endcase
         end
         // Register writes; a launch only takes an idle channel
         if (lnk.cfgWr) begin
            unique case (cfgReg)
               REG_MODE: modeR[cfgCh] <= lnk.cfgWdata[MODE_W-1:0];
               REG_PCIA: pciA[cfgCh] <= lnk.cfgWdata;
               REG_LOCA: locA[cfgCh] <= lnk.cfgWdata;
               REG_CNT: cnt[cfgCh] <= lnk.cfgWdata;
               REG_DESC: descP[cfgCh] <= lnk.cfgWdata;
               default: begin
               end
            endcase
         end
         if (launch) begin
            done[cfgCh] <= 1'b0;
            eotSeen[cfgCh] <= 1'b0;
            perr[cfgCh] <= 1'b0;
            actual[cfgCh] <= 32'h0000_0000;
            step[cfgCh] <= 2'd0;
            dirR[cfgCh] <= modeR[cfgCh][M_TOLOC];
            st[cfgCh] <= modeR[cfgCh][M_SG] ? ST_FETCH : ST_RD;
         end
         // A beat acknowledged in this cycle still counts; abort then follows next cycle
         for (int i = 0; i < CH_N; i++) begin
            if (!lnk.eotN[i] && (st[i] == ST_RD || st[i] == ST_WR)
                  && !(ackIn && cur == 1'(i))) begin
               st[i] <= finishTo(modeR[i]);
               step[i] <= modeR[i][M_WB] ? 2'd0 : 2'd2;
               done[i] <= !modeR[i][M_SG];
               eotSeen[i] <= 1'b1;
               if (reqOn && cur == 1'(i)) begin
                  busReqR <= 2'b00;
               end
            end
            dackR[i] <= !(reqOn && cur == 1'(i) && inData && modeR[i][M_DEMAND]);
            chBusy[i] <= st[i] != ST_IDLE;
         end
         if (lnk.cfgRd) begin
            unique case (cfgReg)
               REG_MODE: cfgRdR <= {20'h0_0000, modeR[cfgCh]};
               REG_PCIA: cfgRdR <= pciA[cfgCh];
               REG_LOCA: cfgRdR <= locA[cfgCh];
               REG_CNT: cfgRdR <= cnt[cfgCh];
               REG_DESC: cfgRdR <= descP[cfgCh];
               REG_CSR: cfgRdR <= {27'h0, st[cfgCh] != ST_IDLE, perr[cfgCh],
                  eotSeen[cfgCh], done[cfgCh], 1'b0};
               REG_ACT: cfgRdR <= actual[cfgCh];
               default: cfgRdR <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

/* File: bdde_host.sv */
// Bus side of the DMA engine: command registers over Avalon-MM, shared memory
// answering both buses, and the peripheral control lines.
// Assumes one Avalon master on the same clock.
module bdde_host
   import bdde_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [AV_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Engine side
   bdde_link_if.host lnk
);
   // ****************************************
   // State
   // ****************************************
   logic [31:0] mem [64];
   logic [1:0] wc;
   logic [9:0] ctrl;
   logic cfgWrR;
   logic cfgRdR;
   logic [CFG_AW-1:0] cfgAddrR;
   logic [31:0] cfgWdataR;
   logic [1:0] ackR;
   logic [1:0] retryR;
   logic [1:0] parR;
   logic [1:0][31:0] rdR;

   wire req = avs_read || avs_write;
   wire isCfg = avs_address < 8'h10;
   wire isMem = avs_address >= AV_MEM_BASE && avs_address < AV_CTRL;
   wire taken = req && !avs_waitrequest;
   wire [5:0] avIdx = avs_address[5:0];

   assign lnk.cfgWr = cfgWrR;
   assign lnk.cfgRd = cfgRdR;
   assign lnk.cfgAddr = cfgAddrR;
   assign lnk.cfgWdata = cfgWdataR;
   assign lnk.busAck = ackR;
   assign lnk.busRetry = retryR;
   assign lnk.busPar = parR;
   assign lnk.busRdata = rdR;
   assign lnk.eotN = ctrl[K_EOT +: 2];
   assign lnk.dreqN = ctrl[K_DMA_REQUEST_N +: 2];
   assign lnk.directBusy = ctrl[K_DIRECT +: 2];

   // ****************************************
   // Avalon side and memory
   // ****************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         wc <= 2'h0;
         ctrl <= 10'h00F;
         cfgWrR <= 1'b0;
         cfgRdR <= 1'b0;
         cfgAddrR <= '0;
         cfgWdataR <= 32'h0000_0000;
         ackR <= 2'b00;
         retryR <= 2'b00;
         parR <= 2'b00;
         rdR <= '0;
      end else begin
         cfgWrR <= 1'b0;
         cfgRdR <= 1'b0;
         if (req && avs_waitrequest) begin
            wc <= 2'(wc + 2'h1);
            if (wc == 2'h0 && isCfg) begin
               // Orders go out in arrival order, so a launch follows its setup
               cfgWrR <= avs_write;
               cfgRdR <= avs_read;
               cfgAddrR <= avs_address[CFG_AW-1:0];
               cfgWdataR <= avs_writedata;
            end
            if (wc == AV_WAIT_LAST) begin
               avs_waitrequest <= 1'b0;
               avs_readdata <= isCfg ? lnk.cfgRdata : isMem ? mem[avIdx]
                  : (avs_address == AV_CTRL) ? {22'h0, ctrl}
                  : (avs_address == AV_STAT) ? {30'h0, lnk.dackN} : 32'h0000_0000;
            end
         end else begin
            avs_waitrequest <= 1'b1;
            wc <= 2'h0;
         end
         // Descriptor words land one by one; software sets valid last
         if (taken && avs_write && isMem) begin
            mem[avIdx] <= avs_writedata;
         end
         if (taken && avs_write && avs_address == AV_CTRL) begin
            ctrl <= avs_writedata[9:0];
         end
         for (int b = 0; b < 2; b++) begin
            ackR[b] <= lnk.busReq[b] && !ackR[b] && !retryR[b] && !ctrl[K_RETRY + b];
            retryR[b] <= lnk.busReq[b] && !ackR[b] && !retryR[b] && ctrl[K_RETRY + b];
            if (lnk.busReq[b] && !ackR[b] && !retryR[b]) begin
               if (ctrl[K_RETRY + b]) begin
                  ctrl[K_RETRY + b] <= 1'b0;
               end else if (lnk.busWe[b]) begin
                  for (int k = 0; k < 4; k++) begin
                     if (lnk.busBe[b][k]) begin
                        mem[{1'(b), lnk.busAddr[b][6:2]}][k*8 +: 8] <= lnk.busWdata[b][k*8 +: 8];
                     end
                  end
               end else begin
                  rdR[b] <= mem[{1'(b), lnk.busAddr[b][6:2]}];
                  parR[b] <= (^mem[{1'(b), lnk.busAddr[b][6:2]}]) ^ ctrl[K_PFLIP + b];
               end
            end
         end
      end
   end
endmodule

/* File: bdde_props.sv */
// Checker for the link between the DMA engine and its bus side.
// Assumes one clock; the bench places it beside the link.
module bdde_props (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Link
   input wire logic [1:0] busReq,
   input wire logic [1:0] busAck,
   input wire logic [1:0] busRetry,
   input wire logic [1:0][31:0] busAddr,
   input wire logic [1:0][3:0] busBe,
   input wire logic [1:0] directBusy,
   input wire logic [1:0] eotN,
   input wire logic [1:0] dackN
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // ****************
   // Bus requests
   // ****************
   AST_ONE_BUS: assert property (!(&busReq)) else $error("two requests");
   AST_ANS_PCI: assert property ($rose(busReq[0]) |=> busAck[0] || busRetry[0])
      else $error("pci unanswered");
   AST_ANS_LOC: assert property ($rose(busReq[1]) |=> busAck[1] || busRetry[1])
      else $error("local unanswered");
   // End-of-transfer may drop a request early, so only quiet cycles count
   AST_HOLD: assert property ($rose(busReq[0]) && &eotN
      |=> busReq[0] && $stable(busAddr[0])) else $error("request not held");
   AST_DIR_PCI: assert property ($rose(busReq[0]) |-> !$past(directBusy[0]))
      else $error("pci taken from direct");
   AST_DIR_LOC: assert property ($rose(busReq[1]) |-> !$past(directBusy[1]))
      else $error("local taken from direct");
   AST_BE: assert property (busReq[1] |-> busBe[1] != 4'h0) else $error("no lanes");
   AST_DMA_ACKNOWLEDGE_N: assert property ($fell(dackN[0]) |-> $past(|busReq))
      else $error("stray ack");
endmodule

/* File: tb_bridge_dma_descriptor_engine.sv */
// Bench for the DMA engine and its bus side, joined by the link.
// Assumes the Avalon port of the bus side is the only way in.
module tb_bridge_dma_descriptor_engine;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic [31:0] q;
   logic avs_waitrequest;
   logic [1:0] chBusy;
   int miscompares = 0;
   int compares = 0;
   bdde_link_if lnk();
   always #20 mclk = ~mclk;
   bdde_engine i_bdde_engine(.mclk(mclk), .reset(reset), .lnk(lnk.dev), .chBusy(chBusy));
   bdde_host i_bdde_host(.mclk(mclk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lnk(lnk.host));
   bdde_props i_bdde_props(.mclk(mclk), .reset(reset), .busReq(lnk.busReq),
      .busAck(lnk.busAck), .busRetry(lnk.busRetry), .busAddr(lnk.busAddr),
      .busBe(lnk.busBe), .directBusy(lnk.directBusy), .eotN(lnk.eotN), .dackN(lnk.dackN));
   // ****************
   // Bus tasks
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is sampled low; an idle edge follows
   task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      av(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // Only the watchdog ends a wait that never finishes
   task automatic idle(input logic [7:0] csr);
      do av(1'b0, csr, 32'h0); while (q[4] !== 1'b0);
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic regScen();
      av(1'b1, 8'h01, 32'h1234_5678);
      av(1'b1, 8'h09, 32'h0000_00A0);
      rc(8'h01, 32'h1234_5678);
      rc(8'h09, 32'h0000_00A0);
      rc(8'h07, 32'h0);
      rc(8'hFF, 32'h0);
      rc(8'h05, 32'h0);
   endtask
   task automatic blockScen();
      av(1'b1, 8'h40, 32'hAABB_CCDD);
      av(1'b1, 8'h60, 32'h1111_1111);
      av(1'b1, 8'h01, 32'h1);
      av(1'b1, 8'h02, 32'h1);
      av(1'b1, 8'h03, 32'h2);
      av(1'b1, 8'h00, 32'h0000_0040);
      av(1'b1, 8'h05, 32'h1);
      idle(8'h05);
      chk(q & 32'h0000_001E, 32'h0000_0002);
      rc(8'h60, 32'h11BB_CC11);
      rc(8'h06, 32'h2);
   endtask
   task automatic swapScen();
      av(1'b1, 8'h41, 32'h0102_0304);
      av(1'b1, 8'h80, 32'h0000_001F);
      av(1'b1, 8'h09, 32'h4);
      av(1'b1, 8'h0A, 32'h4);
      av(1'b1, 8'h0B, 32'h4);
      av(1'b1, 8'h08, 32'h0000_0060);
      av(1'b1, 8'h0D, 32'h1);
      av(1'b0, 8'h0D, 32'h0);
      chk(q & 32'h0000_0012, 32'h0000_0010);
      // Release the bus with a one-shot retry armed on the PCI side
      av(1'b1, 8'h80, 32'h0000_004F);
      idle(8'h0D);
      rc(8'h61, 32'h0403_0201);
      rc(8'h80, 32'h0000_000F);
   endtask
   task automatic eotScen();
      av(1'b1, 8'h03, 32'h8);
      av(1'b1, 8'h00, 32'h0000_0050);
      av(1'b1, 8'h05, 32'h1);
      av(1'b0, 8'h05, 32'h0);
      chk(q & 32'h0000_0012, 32'h0000_0010);
      chk({30'h0, chBusy}, 32'h1);
      av(1'b1, 8'h80, 32'h0000_000E);
      idle(8'h05);
      chk(q & 32'h0000_0014, 32'h0000_0004);
      rc(8'h06, 32'h0);
      // Bad parity on PCI reads: data still moves, error is flagged
      av(1'b1, 8'h80, 32'h0000_0103);
      av(1'b1, 8'h01, 32'h0);
      av(1'b1, 8'h02, 32'h0);
      av(1'b1, 8'h03, 32'h4);
      av(1'b1, 8'h05, 32'h1);
      idle(8'h05);
      chk(q & 32'h0000_001E, 32'h0000_000A);
      rc(8'h06, 32'h4);
      rc(8'h60, 32'hAABB_CCDD);
      av(1'b1, 8'h80, 32'h0000_000F);
   endtask
   task automatic chainScen();
      av(1'b1, 8'h50, 32'h0);
      av(1'b1, 8'h51, 32'h8);
      av(1'b1, 8'h52, 32'h4);
      av(1'b1, 8'h53, 32'h0000_0007);
      av(1'b1, 8'h04, 32'h0000_0040);
      av(1'b1, 8'h00, 32'h0000_0009);
      av(1'b1, 8'h05, 32'h1);
      idle(8'h05);
      chk(q & 32'h0000_001E, 32'h0000_0002);
      rc(8'h62, 32'hAABB_CCDD);
      rc(8'h52, 32'h4);
      rc(8'h53, 32'h0000_000F);
   endtask
   // Ring of one descriptor in local memory; the channel keeps polling it
   task automatic ringScen();
      av(1'b1, 8'h78, 32'h0);
      av(1'b1, 8'h79, 32'h10);
      av(1'b1, 8'h7A, 32'h4);
      av(1'b1, 8'h7B, 32'h0000_0065);
      av(1'b1, 8'h0C, 32'h0000_0060);
      av(1'b1, 8'h08, 32'h0000_000F);
      av(1'b1, 8'h0D, 32'h1);
      do av(1'b0, 8'h7B, 32'h0); while (q[0] !== 1'b0);
      chk(q, 32'h0000_006C);
      rc(8'h7A, 32'h4);
      rc(8'h64, 32'hAABB_CCDD);
      rc(8'h0D, 32'h0000_0010);
   endtask
   task automatic end_sim();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      regScen();
      blockScen();
      swapScen();
      eotScen();
      chainScen();
      ringScen();
      end_sim();
   end
   // Whole run needs under a thousand cycles; this leaves a wide margin
   initial begin
      repeat (30000) @(posedge mclk);
      miscompares++;
      end_sim();
   end
endmodule
